// ---- logic/radio_tx_pkg.sv ----
package radio_tx_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET       = 8'h00;
  localparam logic [7:0] TX_DATA_OFFSET    = 8'h04;
  localparam logic [7:0] STATUS_OFFSET     = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFFSET   = 8'h10;
  localparam int         ADDR_WIDTH        = 8;

  // Control register fields
  localparam int CTRL_TX_EN_BIT     = 0;
  localparam int CTRL_RX_EN_BIT     = 1;
  localparam int CTRL_EXT_CLK_BIT   = 2;
  localparam int CTRL_CODER_EN_BIT  = 3;
  localparam int CTRL_CODE_LSB      = 4;
  localparam int CTRL_COARSE_LSB    = 8;
  localparam int CTRL_FINE_LSB      = 10;
  localparam int CTRL_WIDTH         = 14;
  localparam logic [13:0] CTRL_RESET = 14'h0000;

  // Status register fields
  localparam int STAT_EMPTY_BIT = 0;
  localparam int STAT_FULL_BIT  = 1;
  localparam int STAT_BUSY_BIT  = 2;
  localparam int STAT_COUNT_LSB = 3;

  // Interrupt status and mask fields
  localparam int IRQ_EMPTY_BIT    = 0;
  localparam int IRQ_OVERFLOW_BIT = 1;
  localparam int IRQ_WIDTH        = 2;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // FIFO geometry
  localparam int FIFO_DEPTH      = 4;
  localparam int FIFO_PTR_WIDTH  = 2;
  localparam int FIFO_CNT_WIDTH  = 3;
  localparam logic [2:0] FIFO_FULL_COUNT = 3'h4;
  localparam int BYTE_WIDTH      = 8;
  localparam logic [2:0] LAST_BIT_INDEX = 3'h7;

  // Baud generator
  localparam logic [11:0] BAUD_OVERSAMPLE = 12'h010;
  localparam int          BAUD_CNT_WIDTH  = 12;

  typedef enum logic [2:0] {
    CODE_NRZ_LEVEL = 3'b000,
    CODE_NRZ_MARK  = 3'b001,
    CODE_MAN_SPACE = 3'b010,
    CODE_MAN_LEVEL = 3'b011
  } line_code_e;

endpackage

// ---- logic/tx_fifo_mem.sv ----
`timescale 1ns/1ps
module tx_fifo_mem (
  input  wire logic                                 pclk,
  input  wire logic                                 presetn,
  input  wire logic                                 wr_en,
  input  wire logic [radio_tx_pkg::FIFO_PTR_WIDTH-1:0] wr_addr,
  input  wire logic [radio_tx_pkg::BYTE_WIDTH-1:0]  wr_data,
  input  wire logic [radio_tx_pkg::FIFO_PTR_WIDTH-1:0] rd_addr,
  output logic      [radio_tx_pkg::BYTE_WIDTH-1:0]  rd_data
);
  import radio_tx_pkg::*;

  logic [BYTE_WIDTH-1:0] mem_reg [FIFO_DEPTH];

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  // Registered read with write bypass so rd_data always shows the head entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= '0;
    end else if (wr_en && (wr_addr == rd_addr)) begin
      rd_data <= wr_data;
    end else begin
      rd_data <= mem_reg[rd_addr];
    end
  end

endmodule

// ---- logic/radio_tx_line_encoder.sv ----
`timescale 1ns/1ps
// Operation
// - Transmitter runs only with transmit enable set and receive enable clear.
// - Symbol rate is input clock over sixteen times coarse times fine factor.
// - Coarse 00 with fine 0000 gives product 1, fine 0001 gives 2.
// - Manchester modes send two symbols per data bit at the divider rate.
// - External bit clock select 0 times bits from the internal baud generator.
// - Coder enabled with select 000 sends NRZ Level.
// - Coder enabled with select 010 sends Manchester Space.
// - Transmit FIFO holds four bytes, full after four writes from empty.
// - Transmit interrupt is raised when the transmit FIFO becomes empty.
// - Empty event fires when last byte enters shift register, still shifting.
// - Coder disabled sends raw bits, allowing deliberate code violations.
// - Coder enable change applies only at the next byte load.
// - Coder select 001 chooses NRZ Mark.
// - Coder select 011 chooses Manchester Level.
module radio_tx_line_encoder (
  input  wire logic                                 pclk,
  input  wire logic                                 presetn,
  input  wire logic                                 psel,
  input  wire logic                                 penable,
  input  wire logic                                 pwrite,
  input  wire logic [radio_tx_pkg::ADDR_WIDTH-1:0]  paddr,
  input  wire logic [31:0]                          pwdata,
  output logic      [31:0]                          prdata,
  output logic                                      pready,
  output logic                                      pslverr,
  input  wire logic                                 ext_bitclk,
  output logic                                      tx_data_out,
  output logic                                      tx_active,
  output logic                                      irq
);
  import radio_tx_pkg::*;

  logic [CTRL_WIDTH-1:0]     ctrl_reg;
  logic [IRQ_WIDTH-1:0]      irq_status_reg;
  logic [IRQ_WIDTH-1:0]      irq_mask_reg;
  logic [31:0]               prdata_reg;
  logic [FIFO_PTR_WIDTH-1:0] wr_ptr_reg;
  logic [FIFO_PTR_WIDTH-1:0] rd_ptr_reg;
  logic [FIFO_CNT_WIDTH-1:0] count_reg;
  logic [BYTE_WIDTH-1:0]     head_data;
  logic [BAUD_CNT_WIDTH-1:0] baud_cnt_reg;
  logic                      ext_clk_prev_reg;
  logic [BYTE_WIDTH-1:0]     shift_reg;
  logic [2:0]                bit_idx_reg;
  logic                      half_reg;
  logic                      busy_reg;
  logic                      coder_en_reg;
  logic [2:0]                code_sel_reg;
  logic                      line_reg;

  logic                      setup_phase;
  logic                      access_phase;
  logic                      addr_mapped;
  logic                      wr_txdata;
  logic                      push;
  logic                      pop;
  logic                      fifo_full;
  logic                      fifo_empty;
  logic                      tx_enabled;
  logic                      symbol_tick;
  logic                      int_tick;
  logic [BAUD_CNT_WIDTH-1:0] baud_period;
  logic                      manch_now;
  logic                      last_symbol;
  logic                      empty_event;
  logic                      overflow_event;
  logic [IRQ_WIDTH-1:0]      irq_events;
  logic [31:0]               read_mux;

  // Divider period in pclk cycles: 16 * coarse factor * fine factor
  function automatic logic [BAUD_CNT_WIDTH-1:0] divider_period(
    input logic [1:0] coarse,
    input logic [3:0] fine
  );
    logic [BAUD_CNT_WIDTH-1:0] coarse_f;
    logic [BAUD_CNT_WIDTH-1:0] fine_f;
    coarse_f = BAUD_CNT_WIDTH'(1) << coarse;
    fine_f   = BAUD_CNT_WIDTH'(fine) + BAUD_CNT_WIDTH'(1);
    return BAUD_CNT_WIDTH'(BAUD_OVERSAMPLE * coarse_f * fine_f);
  endfunction

  function automatic logic is_manchester(input logic en, input logic [2:0] sel);
    return en && ((sel == CODE_MAN_SPACE) || (sel == CODE_MAN_LEVEL));
  endfunction

  // Line level for one symbol given data bit, symbol half and previous level
  function automatic logic encode_symbol(
    input logic       en,
    input logic [2:0] sel,
    input logic       data_bit,
    input logic       half,
    input logic       prev
  );
    logic lvl;
    lvl = data_bit;
    if (en) begin
      unique case (sel)
        CODE_NRZ_LEVEL: lvl = data_bit;
        CODE_NRZ_MARK:  lvl = prev ^ data_bit;
        CODE_MAN_SPACE: lvl = half ? (data_bit ? prev : ~prev)
                                   : ~prev;
        CODE_MAN_LEVEL: lvl = half ? ~data_bit : data_bit;
        default:        lvl = data_bit;
      endcase
    end
    return lvl;
  endfunction

  // APB decode
  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign addr_mapped  = (paddr == CTRL_OFFSET) || (paddr == TX_DATA_OFFSET) ||
                        (paddr == STATUS_OFFSET) || (paddr == IRQ_STATUS_OFFSET) ||
                        (paddr == IRQ_MASK_OFFSET);
  assign pready       = 1'b1;
  assign pslverr      = access_phase && !addr_mapped;
  assign prdata       = prdata_reg;
  assign wr_txdata    = access_phase && pwrite && (paddr == TX_DATA_OFFSET);

  // FIFO state
  assign fifo_full  = (count_reg == FIFO_FULL_COUNT);
  assign fifo_empty = (count_reg == '0);
  assign push       = wr_txdata && !fifo_full;
  assign overflow_event = wr_txdata && fifo_full;

  always_comb begin
    read_mux = '0;
    unique case (paddr)
      CTRL_OFFSET:       read_mux[CTRL_WIDTH-1:0] = ctrl_reg;
      STATUS_OFFSET: begin
        read_mux[STAT_EMPTY_BIT] = fifo_empty;
        read_mux[STAT_FULL_BIT]  = fifo_full;
        read_mux[STAT_BUSY_BIT]  = busy_reg;
        read_mux[STAT_COUNT_LSB +: FIFO_CNT_WIDTH] = count_reg;
      end
      IRQ_STATUS_OFFSET: read_mux[IRQ_WIDTH-1:0] = irq_status_reg;
      IRQ_MASK_OFFSET:   read_mux[IRQ_WIDTH-1:0] = irq_mask_reg;
      default:           read_mux = '0;
    endcase
  end

  // Read data is captured in the setup cycle and held through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else if (setup_phase && !pwrite) begin
      prdata_reg <= read_mux;
    end
  end

  // Control and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg     <= CTRL_RESET;
      irq_mask_reg <= IRQ_RESET;
    end else if (access_phase && pwrite) begin
      if (paddr == CTRL_OFFSET) begin
        ctrl_reg <= pwdata[CTRL_WIDTH-1:0];
      end
      if (paddr == IRQ_MASK_OFFSET) begin
        irq_mask_reg <= pwdata[IRQ_WIDTH-1:0];
      end
    end
  end

  // Sticky events, cleared by writing one; a new event wins over the clear
  assign irq_events = {overflow_event, empty_event};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= IRQ_RESET;
    end else begin
      if (access_phase && pwrite && (paddr == IRQ_STATUS_OFFSET)) begin
        irq_status_reg <= (irq_status_reg & ~pwdata[IRQ_WIDTH-1:0]) | irq_events;
      end else begin
        irq_status_reg <= irq_status_reg | irq_events;
      end
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // FIFO pointers; bytes leave in write order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + FIFO_PTR_WIDTH'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + FIFO_PTR_WIDTH'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + FIFO_CNT_WIDTH'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - FIFO_CNT_WIDTH'(1);
      end
    end
  end

  tx_fifo_mem u_fifo_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (push),
    .wr_addr (wr_ptr_reg),
    .wr_data (pwdata[BYTE_WIDTH-1:0]),
    .rd_addr (pop ? rd_ptr_reg + FIFO_PTR_WIDTH'(1) : rd_ptr_reg),
    .rd_data (head_data)
  );

  // Transmit mode
  assign tx_enabled = ctrl_reg[CTRL_TX_EN_BIT] && !ctrl_reg[CTRL_RX_EN_BIT];
  assign tx_active  = tx_enabled;

  // Baud generator
  assign baud_period = divider_period(ctrl_reg[CTRL_COARSE_LSB +: 2],
                                      ctrl_reg[CTRL_FINE_LSB +: 4]);
  assign int_tick    = (baud_cnt_reg == baud_period - BAUD_CNT_WIDTH'(1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_cnt_reg <= '0;
    end else if (!tx_enabled || int_tick) begin
      baud_cnt_reg <= '0;
    end else begin
      baud_cnt_reg <= baud_cnt_reg + BAUD_CNT_WIDTH'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_clk_prev_reg <= 1'b0;
    end else begin
      ext_clk_prev_reg <= ext_bitclk;
    end
  end

  // Symbol timing from the internal divider unless the external clock is chosen
  assign symbol_tick = tx_enabled &&
                       (ctrl_reg[CTRL_EXT_CLK_BIT] ? (ext_bitclk && !ext_clk_prev_reg)
                                                   : int_tick);

  // Shifter sequencing
  assign manch_now   = is_manchester(coder_en_reg, code_sel_reg);
  assign last_symbol = (bit_idx_reg == LAST_BIT_INDEX) && (!manch_now || half_reg);
  assign pop         = symbol_tick && (!busy_reg || last_symbol) && !fifo_empty;
  assign empty_event = pop && (count_reg == FIFO_CNT_WIDTH'(1)) && !push;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg    <= '0;
      bit_idx_reg  <= '0;
      half_reg     <= 1'b0;
      busy_reg     <= 1'b0;
      coder_en_reg <= 1'b0;
      code_sel_reg <= CODE_NRZ_LEVEL;
      line_reg     <= 1'b0;
    end else if (!tx_enabled) begin
      busy_reg <= 1'b0;
      half_reg <= 1'b0;
      line_reg <= 1'b0;
    end else if (symbol_tick) begin
      if (busy_reg && !last_symbol) begin
        if (manch_now && !half_reg) begin
          half_reg <= 1'b1;
          line_reg <= encode_symbol(coder_en_reg, code_sel_reg, shift_reg[BYTE_WIDTH-1],
                                    1'b1, line_reg);
        end else begin
          half_reg    <= 1'b0;
          bit_idx_reg <= bit_idx_reg + 3'(1);
          shift_reg   <= shift_reg << 1;
          line_reg    <= encode_symbol(coder_en_reg, code_sel_reg,
                                       shift_reg[BYTE_WIDTH-2], 1'b0, line_reg);
        end
      end else if (!fifo_empty) begin
        // Coding settings are latched only as a byte loads
        coder_en_reg <= ctrl_reg[CTRL_CODER_EN_BIT];
        code_sel_reg <= ctrl_reg[CTRL_CODE_LSB +: 3];
        shift_reg    <= head_data;
        bit_idx_reg  <= '0;
        half_reg     <= 1'b0;
        busy_reg     <= 1'b1;
        line_reg     <= encode_symbol(ctrl_reg[CTRL_CODER_EN_BIT],
                                      ctrl_reg[CTRL_CODE_LSB +: 3],
                                      head_data[BYTE_WIDTH-1], 1'b0, line_reg);
      end else begin
        busy_reg <= 1'b0;
      end
    end
  end

  assign tx_data_out = line_reg;

endmodule

// ---- test/radio_tx_line_encoder_assertions.sv ----
`timescale 1ns/1ps
module radio_tx_line_encoder_checker
  import radio_tx_pkg::*;
(
  input wire logic                                pclk,
  input wire logic                                presetn,
  input wire logic                                psel,
  input wire logic                                penable,
  input wire logic                                pwrite,
  input wire logic [radio_tx_pkg::ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0]                         pwdata,
  input wire logic [31:0]                         prdata,
  input wire logic                                pready,
  input wire logic                                pslverr,
  input wire logic                                ext_bitclk,
  input wire logic                                tx_data_out,
  input wire logic                                tx_active,
  input wire logic                                irq
);
  logic        ext_q;
  logic        sc_ok;
  logic        tx_prev;
  logic        acc;
  logic        cwr;
  logic        chg;
  logic        mapped;
  logic [1:0]  crs_q;
  logic [3:0]  fin_q;
  logic [7:0]  age;
  logic [15:0] sc;
  logic [15:0] per;
  assign acc = psel && penable;
  assign cwr = acc && pwrite && paddr == CTRL_OFFSET;
  assign chg = tx_data_out != tx_prev;
  assign per = (16'h0010 << crs_q) * (16'(fin_q) + 16'h0001);
  assign mapped = paddr inside {CTRL_OFFSET, TX_DATA_OFFSET, STATUS_OFFSET,
                                IRQ_STATUS_OFFSET, IRQ_MASK_OFFSET};
  // Shadow of the baud and clock selection, and time since its last write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_q <= 1'b0;
      crs_q <= 2'h0;
      fin_q <= 4'h0;
      age <= 8'h00;
    end else if (cwr) begin
      ext_q <= pwdata[CTRL_EXT_CLK_BIT];
      crs_q <= pwdata[9:8];
      fin_q <= pwdata[13:10];
      age <= 8'h00;
    end else if (age != 8'hFF) begin
      age <= age + 8'h01;
    end
  end
  // Cycles between line changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_prev <= 1'b0;
      sc <= 16'h0000;
      sc_ok <= 1'b0;
    end else begin
      tx_prev <= tx_data_out;
      sc <= chg ? 16'h0001 : sc + 16'h0001;
      sc_ok <= cwr ? 1'b0 : (chg || sc_ok);
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (acc && !mapped |-> pslverr) else $error("no slave error");
  a_mapped_ok: assert property (acc && mapped |-> !pslverr) else $error("spurious slave error");
  a_txdata_zero: assert property (acc && !pwrite && paddr == TX_DATA_OFFSET |->
    prdata == 32'h0000_0000) else $error("data port read not zero");
  a_active_ctrl: assert property (cwr |=> tx_active == ($past(pwdata[0]) && !$past(pwdata[1])))
    else $error("tx_active wrong");
  a_tx_gate: assert property (!tx_active ##1 !tx_active |-> !tx_data_out)
    else $error("line driven while disabled");
  a_int_period: assert property (chg && sc_ok && !ext_q && tx_active && age > 8'h04 |->
    sc % per == 16'h0000) else $error("symbol period wrong");
  a_ext_tick: assert property (chg && ext_q && tx_active && age > 8'h04 |->
    $past(ext_bitclk) || $past(ext_bitclk, 2) || $past(ext_bitclk, 3)) else $error("change off tick");
  a_irq_masked: assert property (acc && pwrite && paddr == IRQ_MASK_OFFSET &&
    pwdata[1:0] == 2'b00 |=> !irq) else $error("irq with mask clear");
  c_ext_sym: cover property (chg && ext_q);
  c_irq: cover property (irq);
  c_slverr: cover property (pslverr);
endmodule
bind radio_tx_line_encoder radio_tx_line_encoder_checker i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_bitclk(ext_bitclk),
  .tx_data_out(tx_data_out), .tx_active(tx_active), .irq(irq));

// ---- test/radio_link_model.sv ----
`timescale 1ns/1ps
module radio_link_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        tx_data_out,
  input  wire logic        run,
  input  wire logic [7:0]  gap,
  output logic             ext_bitclk,
  output logic [31:0]      cap,
  output logic [5:0]       ncap
);
  logic [7:0] cnt;
  // Bit clock stands still outside a frame; symbols sampled mid-period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      ext_bitclk <= 1'b0;
      cap <= 32'h0000_0000;
      ncap <= 6'h00;
    end else if (!run) begin
      cnt <= 8'h00;
      ext_bitclk <= 1'b0;
      ncap <= 6'h00;
    end else begin
      cnt <= (cnt == gap - 8'h01) ? 8'h00 : cnt + 8'h01;
      ext_bitclk <= cnt == 8'h00;
      if (cnt == gap >> 1) begin
        cap <= {cap[30:0], tx_data_out};
        ncap <= ncap + 6'h01;
      end
    end
  end
endmodule

// ---- test/tb_radio_tx_line_encoder.sv ----
`timescale 1ns/1ps
module tb_radio_tx_line_encoder;
  import radio_tx_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        ext_bitclk, tx_data_out, tx_active, irq, run, lvl, errv;
  logic [7:0]  paddr, gap;
  logic [5:0]  ncap;
  logic [31:0] pwdata, prdata, cap, exp_sym, rdv;
  int          n_mismatch, samples_checked;
  radio_tx_line_encoder i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_bitclk(ext_bitclk), .tx_data_out(tx_data_out),
    .tx_active(tx_active), .irq(irq));
  radio_link_model i_link (.pclk(pclk), .presetn(presetn), .tx_data_out(tx_data_out),
    .run(run), .gap(gap), .ext_bitclk(ext_bitclk), .cap(cap), .ncap(ncap));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task stop_test;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string m);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdv, e, m);
  endtask
  task wait_n(input int n);
    while (ncap < n) begin
      @(posedge pclk);
    end
  endtask
  task enc(input logic [2:0] c, input logic cod, input logic [31:0] d, input int nb);
    logic b;
    for (int i = 0; i < nb * 8; i++) begin
      b = d[31-i];
      if (cod && c == 3'b001) begin
        lvl = lvl ^ b;
        exp_sym = {exp_sym[30:0], lvl};
      end else if (cod && c == 3'b010) begin
        lvl = ~lvl;
        exp_sym = {exp_sym[30:0], lvl};
        lvl = lvl ^ !b;
        exp_sym = {exp_sym[30:0], lvl};
      end else if (cod && c == 3'b011) begin
        exp_sym = {exp_sym[29:0], b, ~b};
        lvl = ~b;
      end else begin
        lvl = b;
        exp_sym = {exp_sym[30:0], b};
      end
    end
  endtask
  task cmp_sym(input int n, input string m);
    logic [31:0] mk;
    mk = (n == 32) ? 32'hFFFF_FFFF : (32'h0000_0001 << n) - 32'h0000_0001;
    chk(cap & mk, exp_sym & mk, m);
  endtask
  task ser(input logic [2:0] c, input logic cod, input logic [31:0] d, input int nw,
           input int nb, input logic [7:0] g);
    int n;
    apb(1'b1, CTRL_OFFSET, {25'h0, c, cod, 3'b101});
    for (int i = 0; i < nw; i++) apb(1'b1, TX_DATA_OFFSET, {24'h0, d[31-8*i -: 8]});
    exp_sym = 32'h0000_0000;
    lvl = 1'b0;
    enc(c, cod, d, nb);
    n = nb * ((cod && c[2:1] == 2'b01) ? 16 : 8);
    gap <= g;
    run <= 1'b1;
    wait_n(n);
    run <= 1'b0;
    cmp_sym(n, "serial stream");
    apb(1'b1, CTRL_OFFSET, 32'h0000_0000);
  endtask
  task s_period(input logic [31:0] c, input int per);
    int k;
    apb(1'b1, CTRL_OFFSET, c);
    apb(1'b1, TX_DATA_OFFSET, 32'h0000_0055);
    for (k = 0; k < 2000 && tx_data_out !== 1'b1; k++) @(posedge pclk);
    for (k = 0; k < 2000 && tx_data_out === 1'b1; k++) @(posedge pclk);
    chk(32'(k), 32'(per), "symbol period");
    apb(1'b1, CTRL_OFFSET, 32'h0000_0000);
  endtask
  task s_regs;
    rd(CTRL_OFFSET, 32'h0000_0000, "ctrl reset");
    rd(STATUS_OFFSET, 32'h0000_0001, "status reset");
    rd(IRQ_MASK_OFFSET, 32'h0000_0000, "mask reset");
    rd(TX_DATA_OFFSET, 32'h0000_0000, "data port read");
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(32'(errv), 32'h0000_0001, "unmapped access");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, CTRL_OFFSET, 32'(i));
      chk(32'(tx_active), 32'(i == 1), "transmit enable");
    end
  endtask
  task s_fifo;
    for (int i = 0; i < 4; i++) apb(1'b1, TX_DATA_OFFSET, {24'h0, 8'hA5 ^ 8'(i * 8'h33)});
    rd(STATUS_OFFSET, 32'h0000_0022, "fifo full");
    apb(1'b1, TX_DATA_OFFSET, 32'h0000_00FF);
    rd(IRQ_STATUS_OFFSET, 32'h0000_0002, "overflow event");
    chk(32'(irq), 32'h0000_0000, "irq masked");
    apb(1'b1, IRQ_MASK_OFFSET, 32'h0000_0002);
    chk(32'(irq), 32'h0000_0001, "irq unmasked");
    apb(1'b1, IRQ_STATUS_OFFSET, 32'h0000_0002);
    chk(32'(irq), 32'h0000_0000, "irq cleared");
    apb(1'b1, IRQ_MASK_OFFSET, 32'h0000_0000);
    ser(3'b000, 1'b1, 32'hA596_C33C, 0, 4, 8'h08);
    rd(IRQ_STATUS_OFFSET, 32'h0000_0001, "empty event");
    apb(1'b1, IRQ_STATUS_OFFSET, 32'h0000_0003);
  endtask
  task s_switch;
    apb(1'b1, IRQ_MASK_OFFSET, 32'h0000_0001);
    apb(1'b1, CTRL_OFFSET, 32'h0000_0025);
    apb(1'b1, TX_DATA_OFFSET, 32'h0000_0000);
    gap <= 8'h0C;
    run <= 1'b1;
    wait_n(3);
    chk(32'(irq), 32'h0000_0001, "irq during shift");
    apb(1'b1, IRQ_STATUS_OFFSET, 32'h0000_0001);
    apb(1'b1, CTRL_OFFSET, 32'h0000_002D);
    apb(1'b1, TX_DATA_OFFSET, 32'h0000_00C5);
    wait_n(24);
    run <= 1'b0;
    exp_sym = 32'h0000_0000;
    lvl = 1'b0;
    enc(3'b010, 1'b0, 32'h0000_0000, 1);
    enc(3'b010, 1'b1, 32'hC500_0000, 1);
    cmp_sym(24, "coder switch");
    rd(IRQ_STATUS_OFFSET, 32'h0000_0001, "empty again");
    apb(1'b1, CTRL_OFFSET, 32'h0000_0000);
  endtask
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    run = 1'b0;
    gap = 8'h08;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_regs;
    s_fifo;
    for (int i = 0; i < 5; i++)
      ser(3'(i + 1), i != 3, 32'hB200_0000, 1, 1, i[0] ? 8'h14 : 8'h08);
    s_switch;
    s_period(32'h0000_0001, 16);
    s_period(32'h0000_0401, 32);
    s_period(32'h0000_0101, 32);
    stop_test;
  end
  initial begin
    #2_400_000;
    n_mismatch++;
    stop_test;
  end
endmodule
